// >>> pkg/vcb_regs.vh
`ifndef VCB_REGS_VH
`define VCB_REGS_VH
// Register byte offsets of the first engine; the second engine sits one bank above.
`define VCB_OFS_VBI_MAX 12'h338
`define VCB_OFS_PROGRESS 12'h33C
`define VCB_OFS_VBUF0 12'h340
`define VCB_OFS_VBUF1 12'h344
`define VCB_OFS_VBUF2 12'h348
`define VCB_OFS_VBI1 12'h34C
`define VCB_OFS_STRIDE 12'h350
`define VCB_OFS_ERR0 12'h354
`define VCB_OFS_ERR1 12'h358
`define VCB_OFS_ERR2 12'h35C
`define VCB_OFS_CTRL 12'h360
`define VCB_ENGINE_STEP 16'h1000
// Writable bit masks; everything else reads as zero.
`define VCB_MASK_VBI_MAX 32'h07FF01FF
`define VCB_MASK_BASE 32'h1FFFFFF3
`define VCB_MASK_STRIDE 32'h00FF1FF0
`define VCB_MASK_CTRL 32'h00000007
// Field positions.
`define VCB_LINE_LSB 16
`define VCB_CORE_EN_BIT 23
`define VCB_CORE_THR_LSB 16
`define VCB_STRIDE_LSB 4
`define VCB_BASE_LSB 4
`define VCB_CTRL_CAP_EN 0
`define VCB_CTRL_TRIPLE 1
`define VCB_CTRL_STREAM 2
`define VCB_RESP_OKAY 2'h0
`define VCB_RESP_SLVERR 2'h2
`endif

// >>> core/vcb_capture_regs.v
`timescale 1ns/1ps
`include "vcb_regs.vh"
module vcb_capture_regs #(
	parameter NUM_ENGINES = 2
) (
	// Clock and reset
	input wire REF_CLK_IN,
	input wire RSTN_IN,
	// AXI4-Lite write
	input wire [15:0] S_AXI_AWADDR_IN,
	input wire S_AXI_AWVALID_IN,
	output reg S_AXI_AWREADY_OUT,
	input wire [31:0] S_AXI_WDATA_IN,
	input wire [3:0] S_AXI_WSTRB_IN,
	input wire S_AXI_WVALID_IN,
	output reg S_AXI_WREADY_OUT,
	output reg [1:0] S_AXI_BRESP_OUT,
	output reg S_AXI_BVALID_OUT,
	input wire S_AXI_BREADY_IN,
	// AXI4-Lite read
	input wire [15:0] S_AXI_ARADDR_IN,
	input wire S_AXI_ARVALID_IN,
	output reg S_AXI_ARREADY_OUT,
	output reg [31:0] S_AXI_RDATA_OUT,
	output reg [1:0] S_AXI_RRESP_OUT,
	output reg S_AXI_RVALID_OUT,
	input wire S_AXI_RREADY_IN,
	// Video and stream source, one lane per engine
	input wire [NUM_ENGINES-1:0] FIELD_START_IN,
	input wire [NUM_ENGINES-1:0] LINE_START_IN,
	input wire [NUM_ENGINES-1:0] VBI_UNIT_IN,
	input wire [NUM_ENGINES*16-1:0] PIXEL_IN,
	input wire [NUM_ENGINES-1:0] PIXEL_CHROMA_IN,
	input wire [NUM_ENGINES-1:0] PIXEL_VALID_IN,
	input wire [NUM_ENGINES-1:0] PKT_DONE_IN,
	input wire [NUM_ENGINES-1:0] PKT_ERROR_IN,
	input wire [NUM_ENGINES*15-1:0] PKT_ID_IN,
	// Capture outputs, one lane per engine
	output reg [NUM_ENGINES*16-1:0] PIXEL_OUT,
	output reg [NUM_ENGINES-1:0] PIXEL_VALID_OUT,
	output reg [NUM_ENGINES*29-1:0] LINE_ADDR_OUT,
	output reg [NUM_ENGINES*29-1:0] VBI_ADDR_OUT,
	output reg [NUM_ENGINES*2-1:0] PLACEMENT_OUT,
	output reg [NUM_ENGINES*2-1:0] BUFFER_INDEX_OUT,
	output reg [NUM_ENGINES-1:0] VBI_FULL_OUT
);

	// ************************************************
	// Bus slave
	// ************************************************
	// Write address and data are latched independently so either may come first.
	// Unmapped or unaligned offsets answer with an error response and change nothing.
	reg aw_held;
	reg w_held;
	reg [15:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire wr_fire = aw_held && w_held && !S_AXI_BVALID_OUT;
	wire wr_eng = aw_addr[12];
	wire [11:0] wr_ofs = aw_addr[11:0];
	wire wr_hit_bank = (aw_addr[15:13] == 3'h0) && (aw_addr[1:0] == 2'h0);
	reg wr_ok;
	reg [31:0] wr_bytes;
	integer k;

	always @* begin
		for (k = 0; k < 4; k = k + 1) begin
			wr_bytes[k*8 +: 8] = w_strb[k] ? 8'hFF : 8'h00;
		end
		case (wr_ofs)
			`VCB_OFS_VBI_MAX,
			`VCB_OFS_PROGRESS,
			`VCB_OFS_VBUF0,
			`VCB_OFS_VBUF1,
			`VCB_OFS_VBUF2,
			`VCB_OFS_VBI1,
			`VCB_OFS_STRIDE,
			`VCB_OFS_ERR0,
			`VCB_OFS_ERR1,
			`VCB_OFS_ERR2,
			`VCB_OFS_CTRL: wr_ok = wr_hit_bank;
			default: wr_ok = 1'b0;
		endcase
	end

	always @(posedge REF_CLK_IN) begin
		if (!RSTN_IN) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 16'h0000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			S_AXI_AWREADY_OUT <= 1'b0;
			S_AXI_WREADY_OUT <= 1'b0;
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= 2'h0;
		end else begin
			S_AXI_AWREADY_OUT <= !aw_held && !S_AXI_AWREADY_OUT && S_AXI_AWVALID_IN;
			S_AXI_WREADY_OUT <= !w_held && !S_AXI_WREADY_OUT && S_AXI_WVALID_IN;
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR_IN;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA_IN;
				w_strb <= S_AXI_WSTRB_IN;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT <= wr_ok ? `VCB_RESP_OKAY : `VCB_RESP_SLVERR;
			end else if (S_AXI_BREADY_IN) begin
				S_AXI_BVALID_OUT <= 1'b0;
			end
		end
	end

	// ************************************************
	// Read channel
	// ************************************************
	// Read path: one cycle of decode after the address is taken.
	// The extra cycle keeps the wide read mux off the address flop's path.
	reg rd_pend;
	reg [15:0] ar_addr;
	reg [31:0] rd_word [0:NUM_ENGINES-1];
	reg rd_ok;
	reg [31:0] rd_mux;
	wire rd_eng = ar_addr[12];
	wire rd_hit_bank = (ar_addr[15:13] == 3'h0) && (ar_addr[1:0] == 2'h0);

	// ************************************************
	// Engines
	// ************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_ENGINES; g = g + 1) begin : eng
			reg [31:0] vbi_max;
			reg [31:0] vbase [0:2];
			reg [31:0] vbi_base1;
			reg [31:0] stride_coring;
			reg [2:0] ctrl;
			reg [10:0] line_cnt;
			reg [12:0] vbi_cnt;
			reg [31:0] err [0:2];
			reg [1:0] buf_idx;
			reg vbi_sel;
			reg [8:0] vbi_units_line;
			reg [10:0] vbi_lines;
			reg [28:0] line_addr;
			wire sel = wr_fire && wr_ok && (wr_eng == g);
			wire [31:0] wd = w_data & wr_bytes;
			wire [31:0] wm = ~wr_bytes;

			// ****************************************
			// Coring
			// ****************************************
			wire [6:0] thr = stride_coring[`VCB_CORE_THR_LSB +: 7];
			wire [7:0] cval = PIXEL_IN[g*16 +: 8];
			// Signed band test: -thr+1 <= c <= thr.
			wire signed [8:0] cs = {cval[7], cval};
			wire signed [8:0] hi = {2'b00, thr};
			wire signed [8:0] lo = 9'sd1 - hi;
			wire in_band = (cs >= lo) && (cs <= hi);
			wire core = stride_coring[`VCB_CORE_EN_BIT] && PIXEL_CHROMA_IN[g] && in_band;

			// ****************************************
			// Buffer rotation
			// ****************************************
			// The same rotation serves frame buffers and stream buffers.
			wire [1:0] last_idx = ctrl[`VCB_CTRL_TRIPLE] ? 2'd2 : 2'd1;
			wire [1:0] nxt_idx = (buf_idx == last_idx) ? 2'd0 : buf_idx + 2'd1;
			wire [28:0] nxt_base = {vbase[nxt_idx][28:4], 4'h0};
			// The first VBI base register lies outside this block; its base is fixed here.
			localparam [28:0] VBI0_BASE_DEF = 29'h0;
			wire [28:0] vbi_b0 = {VBI0_BASE_DEF[28:4], 4'h0};
			wire [28:0] step = {17'h00000, stride_coring[12:4], 3'b000};
			wire en = ctrl[`VCB_CTRL_CAP_EN];
			wire cur_err = PKT_DONE_IN[g] && PKT_ERROR_IN[g] && en && ctrl[`VCB_CTRL_STREAM];

			// ****************************************
			// Engine state
			// ****************************************

			always @(posedge REF_CLK_IN) begin
				if (!RSTN_IN) begin
					vbi_max <= 32'h0;
					vbase[0] <= 32'h0;
					vbase[1] <= 32'h0;
					vbase[2] <= 32'h0;
					vbi_base1 <= 32'h0;
					stride_coring <= 32'h0;
					ctrl <= 3'h0;
					line_cnt <= 11'h0;
					vbi_cnt <= 13'h0;
					err[0] <= 32'h0;
					err[1] <= 32'h0;
					err[2] <= 32'h0;
					buf_idx <= 2'h0;
					vbi_sel <= 1'b0;
					vbi_units_line <= 9'h0;
					vbi_lines <= 11'h0;
					line_addr <= 29'h0;
					PIXEL_OUT[g*16 +: 16] <= 16'h0000;
					PIXEL_VALID_OUT[g] <= 1'b0;
					LINE_ADDR_OUT[g*29 +: 29] <= 29'h0;
					VBI_ADDR_OUT[g*29 +: 29] <= 29'h0;
					PLACEMENT_OUT[g*2 +: 2] <= 2'h0;
					BUFFER_INDEX_OUT[g*2 +: 2] <= 2'h0;
					VBI_FULL_OUT[g] <= 1'b0;
				end else begin
					// Coring acts only on chroma inside the band.
					PIXEL_OUT[g*16 +: 16] <= core ? {PIXEL_IN[g*16+8 +: 8], 8'h00}
						: PIXEL_IN[g*16 +: 16];
					PIXEL_VALID_OUT[g] <= PIXEL_VALID_IN[g] && en;
					if (en && FIELD_START_IN[g]) begin
						// Field start moves to the next buffer in the rotation.
						buf_idx <= nxt_idx;
						line_cnt <= 11'h0;
						line_addr <= nxt_base;
						vbi_sel <= ~vbi_sel;
						vbi_lines <= 11'h0;
						vbi_units_line <= 9'h0;
						vbi_cnt <= 13'h0;
						err[nxt_idx] <= 32'h0;
					end else if (en && LINE_START_IN[g]) begin
						line_cnt <= line_cnt + 11'd1;
						line_addr <= line_addr + step;
						vbi_units_line <= 9'h0;
						if (vbi_units_line != 9'h0)
							vbi_lines <= vbi_lines + 11'd1;
					end else if (en && VBI_UNIT_IN[g] && !VBI_FULL_OUT[g]) begin
						vbi_cnt <= vbi_cnt + 13'd1;
						vbi_units_line <= vbi_units_line + 9'd1;
					end
					// Capture is refused once either VBI limit is met.
					VBI_FULL_OUT[g] <= (vbi_units_line >= vbi_max[8:0])
						|| (vbi_lines >= vbi_max[26:16]);

					// ********************************
					// Error reports
					// ********************************
					// Only the buffer now in use collects errors.
					if (cur_err) begin
						if (!err[buf_idx][15])
							err[buf_idx][15:0] <= {1'b1, PKT_ID_IN[g*15 +: 15]};
						else
							err[buf_idx][31:16] <= {1'b1, PKT_ID_IN[g*15 +: 15]};
					end
					LINE_ADDR_OUT[g*29 +: 29] <= line_addr;
					VBI_ADDR_OUT[g*29 +: 29] <= vbi_sel ? {vbi_base1[28:4], 4'h0} : vbi_b0;
					PLACEMENT_OUT[g*2 +: 2] <= vbase[buf_idx][1:0];
					BUFFER_INDEX_OUT[g*2 +: 2] <= buf_idx;

					// ********************************
					// Register writes
					// ********************************
					// A bus write lands after any event update of the same edge.
					if (sel) begin
						case (wr_ofs)
							`VCB_OFS_VBI_MAX: vbi_max <= (vbi_max & wm)
								| (wd & `VCB_MASK_VBI_MAX);
							`VCB_OFS_PROGRESS: begin
								if (wr_bytes[16])
									line_cnt[7:0] <= w_data[23:16];
								if (wr_bytes[24])
									line_cnt[10:8] <= w_data[26:24];
								if (wr_bytes[0])
									vbi_cnt[7:0] <= w_data[7:0];
								if (wr_bytes[8])
									vbi_cnt[12:8] <= w_data[12:8];
							end
							`VCB_OFS_VBUF0: vbase[0] <= (vbase[0] & wm) | (wd & `VCB_MASK_BASE);
							`VCB_OFS_VBUF1: vbase[1] <= (vbase[1] & wm) | (wd & `VCB_MASK_BASE);
							`VCB_OFS_VBUF2: vbase[2] <= (vbase[2] & wm) | (wd & `VCB_MASK_BASE);
							`VCB_OFS_VBI1: vbi_base1 <= (vbi_base1 & wm) | (wd & `VCB_MASK_BASE);
							`VCB_OFS_STRIDE: stride_coring <= (stride_coring & wm)
								| (wd & `VCB_MASK_STRIDE);
							`VCB_OFS_CTRL: begin
								if (wr_bytes[0])
									ctrl <= w_data[2:0];
							end
							default: begin
							end
						endcase
					end
				end
			end

			// ****************************************
			// Read data per engine
			// ****************************************
			always @* begin
				case (ar_addr[11:0])
					`VCB_OFS_VBI_MAX: rd_word[g] = vbi_max;
					`VCB_OFS_PROGRESS: rd_word[g] = {5'h0, line_cnt, 3'h0, vbi_cnt};
					`VCB_OFS_VBUF0: rd_word[g] = vbase[0];
					`VCB_OFS_VBUF1: rd_word[g] = vbase[1];
					`VCB_OFS_VBUF2: rd_word[g] = vbase[2];
					`VCB_OFS_VBI1: rd_word[g] = vbi_base1;
					`VCB_OFS_STRIDE: rd_word[g] = stride_coring;
					`VCB_OFS_ERR0: rd_word[g] = err[0];
					`VCB_OFS_ERR1: rd_word[g] = err[1];
					`VCB_OFS_ERR2: rd_word[g] = err[2];
					`VCB_OFS_CTRL: rd_word[g] = {29'h0, ctrl};
					default: rd_word[g] = 32'h0;
				endcase
			end
		end
	endgenerate

	always @* begin
		rd_mux = rd_word[rd_eng];
		case (ar_addr[11:0])
			`VCB_OFS_VBI_MAX,
			`VCB_OFS_PROGRESS,
			`VCB_OFS_VBUF0,
			`VCB_OFS_VBUF1,
			`VCB_OFS_VBUF2,
			`VCB_OFS_VBI1,
			`VCB_OFS_STRIDE,
			`VCB_OFS_ERR0,
			`VCB_OFS_ERR1,
			`VCB_OFS_ERR2,
			`VCB_OFS_CTRL: rd_ok = rd_hit_bank;
			default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge REF_CLK_IN) begin
		if (!RSTN_IN) begin
			rd_pend <= 1'b0;
			ar_addr <= 16'h0000;
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= 32'h00000000;
			S_AXI_RRESP_OUT <= 2'h0;
		end else begin
			S_AXI_ARREADY_OUT <= !rd_pend && !S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT
				&& S_AXI_ARVALID_IN;
			if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
				rd_pend <= 1'b1;
				ar_addr <= S_AXI_ARADDR_IN;
			end
			if (rd_pend) begin
				rd_pend <= 1'b0;
				S_AXI_RVALID_OUT <= 1'b1;
				S_AXI_RDATA_OUT <= rd_ok ? rd_mux : 32'h00000000;
				S_AXI_RRESP_OUT <= rd_ok ? `VCB_RESP_OKAY : `VCB_RESP_SLVERR;
			end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
				S_AXI_RVALID_OUT <= 1'b0;
			end
		end
	end

endmodule // vcb_capture_regs

// >>> verification/vcb_src_model.sv
`timescale 1ns/1ps
module vcb_src_model (
	input wire logic clk,
	output logic [1:0] fs, ls, vu, pv, pc, pd, pe,
	output logic [31:0] px,
	output logic [29:0] pid
);
	initial {fs, ls, vu, pv, pc, pd, pe, px, pid} = '0;
	// Data lines show the inverse once released, so stale values cannot pass as fresh ones.
	task automatic send(input int e, input logic [6:0] c, input logic [15:0] d,
		input logic [14:0] id);
		@(posedge clk);
		{fs[e], ls[e], vu[e], pv[e], pc[e], pd[e], pe[e]} <= c;
		px[e*16+:16] <= d;
		pid[e*15+:15] <= id;
		@(posedge clk);
		{fs[e], ls[e], vu[e], pv[e], pc[e], pd[e], pe[e]} <= 7'h00;
		px[e*16+:16] <= ~d;
		pid[e*15+:15] <= ~id;
	endtask
endmodule // vcb_src_model

// >>> verification/vcb_capture_regs_chk.sv
`timescale 1ns/1ps
module vcb_capture_regs_chk #(parameter NUM_ENGINES = 2) (
	input wire logic REF_CLK_IN, RSTN_IN, S_AXI_AWVALID_IN, S_AXI_AWREADY_OUT,
	input wire logic S_AXI_BVALID_OUT, S_AXI_BREADY_IN, S_AXI_ARVALID_IN,
	input wire logic S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT, S_AXI_RREADY_IN,
	input wire logic [NUM_ENGINES*16-1:0] PIXEL_IN, PIXEL_OUT,
	input wire logic [NUM_ENGINES-1:0] PIXEL_CHROMA_IN, PIXEL_VALID_IN, PIXEL_VALID_OUT,
	input wire logic [NUM_ENGINES*2-1:0] BUFFER_INDEX_OUT
);
	default clocking @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);
	sequence aw_take;
		S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
	endsequence
	sequence ar_take;
		S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
	endsequence
	write_answer_a: assert property (aw_take |-> ##[1:4] S_AXI_BVALID_OUT)
		else $error("write answer late");
	write_release_a: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT)
		else $error("write answer repeated");
	read_answer_a: assert property (ar_take |-> ##[1:4] S_AXI_RVALID_OUT)
		else $error("read answer late");
	read_release_a: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT)
		else $error("read answer repeated");
	pixel_valid_a: assert property (PIXEL_VALID_OUT[0] |-> $past(PIXEL_VALID_IN[0]))
		else $error("pixel valid without input");
	upper_pass_a: assert property (PIXEL_VALID_OUT[0] |-> PIXEL_OUT[15:8] == $past(PIXEL_IN[15:8]))
		else $error("upper byte altered");
	luma_pass_a: assert property (PIXEL_VALID_OUT[0] && !$past(PIXEL_CHROMA_IN[0])
		|-> PIXEL_OUT[7:0] == $past(PIXEL_IN[7:0]))
		else $error("luma altered");
	buffer_index_a: assert property (BUFFER_INDEX_OUT[1:0] != 2'h3)
		else $error("buffer index out of range");
endmodule // vcb_capture_regs_chk
bind vcb_capture_regs vcb_capture_regs_chk #(.NUM_ENGINES(NUM_ENGINES)) u_chk (.*);

// >>> verification/vcb_capture_regs_test.sv
`timescale 1ns/1ps
`include "vcb_regs.vh"
module vcb_capture_regs_test;
	logic clk, rstn, awv, wv, bre, arv, rre;
	logic [15:0] awa, ara;
	logic [31:0] wd, x, seed;
	logic [31:0] mdl [2][12];
	logic [31:0] rep [3];
	wire awr, wrd, bv, arr, rv;
	wire [1:0] br, rr, fs, ls, vu, pv, pc, pd, pe, vo;
	wire [31:0] rdat, po, px;
	wire [57:0] la, va;
	wire [1:0] vf;
	wire [3:0] pl, bx;
	wire [29:0] pid;
	int error_cnt, cmp_count, bi, e, i, f, k, s, t;
	vcb_src_model u_vcb_src_model (.clk(clk), .fs(fs), .ls(ls), .vu(vu), .pv(pv), .pc(pc),
		.pd(pd), .pe(pe), .px(px), .pid(pid));
	vcb_capture_regs u_vcb_capture_regs (.REF_CLK_IN(clk), .RSTN_IN(rstn),
		.S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
		.S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
		.S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
		.S_AXI_BREADY_IN(bre), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
		.S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr),
		.S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rre), .FIELD_START_IN(fs),
		.LINE_START_IN(ls), .VBI_UNIT_IN(vu), .PIXEL_IN(px), .PIXEL_CHROMA_IN(pc),
		.PIXEL_VALID_IN(pv), .PKT_DONE_IN(pd), .PKT_ERROR_IN(pe), .PKT_ID_IN(pid),
		.PIXEL_OUT(po), .PIXEL_VALID_OUT(vo), .LINE_ADDR_OUT(la), .VBI_ADDR_OUT(va),
		.PLACEMENT_OUT(pl), .BUFFER_INDEX_OUT(bx), .VBI_FULL_OUT(vf));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] msk(input int i);
		case (i)
			0: return `VCB_MASK_VBI_MAX;
			1: return 32'h07FF1FFF;
			2, 3, 4, 5: return `VCB_MASK_BASE;
			6: return `VCB_MASK_STRIDE;
			10: return `VCB_MASK_CTRL;
			default: return 32'h00000000;
		endcase
	endfunction
	function automatic logic [15:0] adr(input int e, i);
		return `VCB_OFS_VBI_MAX + {i[13:0], 2'h0} + (e ? `VCB_ENGINE_STEP : 16'h0000);
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] w);
		cmp_count++;
		if (g !== w) begin
			error_cnt++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, w);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic hang();
		error_cnt++;
		finish_test();
	endtask
	task automatic wr(input int e, i, input logic [31:0] d);
		int n;
		@(posedge clk);
		awa <= adr(e, i);
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv) break;
		end
		bre <= 1'b0;
		if (n == 50) hang();
		chk(br, i > 10 ? `VCB_RESP_SLVERR : `VCB_RESP_OKAY);
		mdl[e][i] = d & msk(i);
	endtask
	task automatic rd(input int e, i);
		int n;
		@(posedge clk);
		ara <= adr(e, i);
		arv <= 1'b1;
		rre <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		rre <= 1'b0;
		if (n == 50) hang();
		chk(rr, i > 10 ? `VCB_RESP_SLVERR : `VCB_RESP_OKAY);
		chk(rdat, mdl[e][i]);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ****************
	// Scenarios
	// ****************
	initial begin
		{rstn, awv, wv, bre, arv, rre, awa, ara, wd} = '0;
		seed = 32'h000113DF;
		mdl = '{default: 32'h0};
		rep = '{default: 32'h0};
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		for (k = 0; k < 3; k++) for (e = 0; e < 2; e++) for (i = 0; i < 12; i++)
			if (k == 1) wr(e, i, rnd());
			else rd(e, i);
		wr(0, 6, rnd() | 32'h00800000);
		wr(0, 10, 32'h1);
		t = mdl[0][6][22:16];
		for (s = -128; s < 128; s++) begin
			x = rnd();
			u_vcb_src_model.send(0, {4'h1, x[0], 2'h0}, {x[15:8], s[7:0]}, 15'h0);
			#1;
			chk({vo[0], po[15:0]}, {1'b1, x[15:8],
				(x[0] && s >= 1 - t && s <= t) ? 8'h00 : s[7:0]});
		end
		wr(0, 10, 32'h0);
		u_vcb_src_model.send(0, 7'h08, 16'h1234, 15'h0);
		#1;
		chk(vo[0], 1'b0);
		wr(0, 0, 32'h07FF01FF);
		for (f = 0; f < 7; f++) begin
			if (f == 0 || f == 3) wr(0, 10, f < 3 ? 32'h1 : 32'h7);
			u_vcb_src_model.send(0, 7'h40, 16'h0, 15'h0);
			bi = (bi + 1) % (f < 3 ? 2 : 3);
			rep[bi] = 32'h0;
			for (k = 0; k < 5; k++) u_vcb_src_model.send(0, k < 3 ? 7'h20 : 7'h10, 16'h0, 15'h0);
			for (k = 0; k <= (5 - f) % 3; k++) begin
				x = rnd();
				u_vcb_src_model.send(0, {6'h01, k < (5 - f) % 3}, 16'h0, x[14:0]);
				if (f > 2 && k < (5 - f) % 3 && rep[bi][15]) rep[bi][31:16] = {1'b1, x[14:0]};
				else if (f > 2 && k < (5 - f) % 3) rep[bi] = {17'h1, x[14:0]};
			end
			repeat (2) @(posedge clk);
			#1;
			chk(bx[1:0], bi);
			chk(pl[1:0], mdl[0][2 + bi][1:0]);
			chk(va[28:0], (f % 2 == 0) ? (mdl[0][5] & 32'h1FFFFFF0) : 32'h0);
			chk(vf[0], 1'b0);
			chk(la[28:0], ((mdl[0][2 + bi] & 32'h1FFFFFF0) + 24 * mdl[0][6][12:4])
				& 32'h1FFFFFFF);
			mdl[0][1] = 32'h00030002;
			rd(0, 1);
			for (k = 0; k < 3 && f > 4; k++) begin
				mdl[0][7 + k] = rep[k];
				rd(0, 7 + k);
			end
		end
		finish_test();
	end
endmodule // vcb_capture_regs_test
